// ---- inc/chan_regs.svh ----
// constants for the processor channel and mode controller
`ifndef CHAN_REGS_SVH
`define CHAN_REGS_SVH

// smallest virtual page, as address bits below the page number
`define CH_PAGE_BITS  10
// addresses at or above this base are burst-capable devices
`define CH_BURST_BASE 32'h80000000
// outstanding fetch requests allowed on the channel
`define CH_MAX_OUT    2
// depth of the instruction buffer
`define CH_BUF_DEPTH  2
// byte step of the prefetch pointer
`define CH_WORD_STEP  32'h00000004
// reset value of both prefetch pointers
`define CH_PTR_RST    32'h00000000

`endif

// ---- inc/chan_pkg.sv ----
// types for the processor channel and mode controller
`default_nettype none
package chan_pkg;

  // externally indicated operating mode, one code each
  typedef enum logic [2:0] {
    MODE_EXEC, MODE_WAIT, MODE_HOLD, MODE_HALT,
    MODE_STEP, MODE_LTI, MODE_TEST, MODE_RESET
  } mode_t;

  typedef enum logic [1:0] {I_IDLE, I_XLATE, I_ADDR, I_BURST} ifsm_t;
  typedef enum logic [1:0] {D_IDLE, D_ADDR, D_WAIT} dfsm_t;

  // one synchroniser stage of all pin inputs
  typedef struct packed {
    logic [31:0] ibus;
    logic [31:0] dbus;
    logic        i_ack;
    logic        i_pipe;
    logic        i_burst;
    logic        d_ack;
    logic        d_pipe;
    logic        ext_req;
    logic        halt;
    logic        step;
    logic        lti;
    logic        test;
    logic        dev_rd;
    logic        dev_wr;
    logic        go;
  } pin_t;

  typedef struct packed {
    pin_t        s1;
    pin_t        s2;
    mode_t       mode;
    logic        halted;
    logic        step_prev;
    logic        core_run;
    ifsm_t       ist;
    logic [31:0] ivp;
    logic [31:0] ipp;
    logic [1:0]  ipend;
    logic [1:0]  idrop;
    logic        need_xl;
    logic        bstale;
    logic        xl_req;
    logic [31:0] xl_vaddr;
    dfsm_t       dst;
    logic        dq_v;
    logic        dq_wr;
    logic        dq_cp;
    logic [31:0] dq_a;
    logic [31:0] dq_w;
    logic        d_wr;
    logic        d_ready;
    logic        rd_valid;
    logic [31:0] rd_data;
    logic        state_wr;
    logic [31:0] state_wdata;
    logic [31:0] addr;
    logic        addr_oe_n;
    logic [31:0] dout;
    logic        dout_oe_n;
    logic        ctl_oe_n;
    logic        i_req;
    logic        data_req;
    logic        rw;
    logic        burst_req;
    logic        copro;
    logic        grant;
  } chan_st_t;

endpackage
`default_nettype wire

// ---- inc/word_stream_if.sv ----
// valid/ready word stream between the controller and its buffer
`timescale 1ns/1ps
`default_nettype none
interface word_stream_if #(parameter int W = 32);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface // word_stream_if
`default_nettype wire

// ---- rtl/word_buffer.sv ----
// small flip-flop fifo with registered head and flush
`timescale 1ns/1ps
`default_nettype none
module word_buffer #(
  parameter int W     = 32,
  parameter int DEPTH = 2,
  parameter int LW    = $clog2(DEPTH + 1)
) (
  input  wire logic          clk,
  input  wire logic          srst,
  input  wire logic          flush,
  output logic [LW-1:0]      level,
  word_stream_if.snk         fill,
  word_stream_if.src         drain
);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [LW-1:0]           cnt;
    logic                    nonempty;
  } buf_st_t;

  buf_st_t st;
  buf_st_t next_st;

  // head always in mem[0] so the drain side sees flops only
  assign fill.ready  = int'(st.cnt) < DEPTH;
  assign drain.valid = st.nonempty;
  assign drain.data  = st.mem[0];
  assign level       = st.cnt;

  // shift on pop, write behind the last valid entry on push
  always_comb begin
    logic push;
    logic pop;
    int   wi;
    push    = fill.valid && (int'(st.cnt) < DEPTH);
    pop     = st.nonempty && drain.ready;
    wi      = 0;
    next_st = st;
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        next_st.mem[i] = st.mem[i + 1];
      end
      next_st.cnt = st.cnt - 1'b1;
    end
    if (push) begin
      wi = int'(next_st.cnt);
      next_st.mem[wi] = fill.data;
      next_st.cnt = next_st.cnt + 1'b1;
    end
    // flush beats a same-cycle push: that word is from the old stream
    if (flush) begin
      next_st.cnt = '0;
    end
    next_st.nonempty = next_st.cnt != '0;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule // word_buffer
`default_nettype wire

// ---- rtl/proc_channel.sv ----
// channel access engine and operating-mode controller of the processor
//
// Behaviour
// - separate 32-bit instruction in, two-way data and shared address buses.
// - address bus also carries operand words to the coprocessor.
// - simple, pipelined or burst chosen per transfer by addressed device.
// - simple access keeps the address driven until its reply completes.
// - pipelined: at most one more address before the first reply.
// - burst: later words follow increasing addresses without resending address.
// - either side may end a burst at any time.
// - a simple access may turn pipelined whenever the responder says, but burst only if burst_req was raised.
// - data accesses run alongside instruction bursts; only address bus shared.
// - arbitration logic grants the channel to an external master.
// - loads and stores arrive already translated; only physical addresses leave.
// - a new translated request is taken while the previous access completes.
// - prefetch pointer increments; translate only after reset, branches and page crossings.
// - current operating mode is shown on outputs.
// - Wait mode runs nothing and accesses nothing until interrupt or reset.
// - interlock stalls execution in Pipeline Hold until it may resume.
// - Halt by instruction or pin; no fetch and no execution.
// - Step behaves as Halt but runs one cycle per step.
// - Load Test Instruction takes instructions from the bus, then resumes sequence.
// - Test mode releases every output for test hardware.
// - development system reads and writes processor state over the data bus.
// - reset initialises control state.
`timescale 1ns/1ps
`default_nettype none
`include "chan_regs.svh"
module proc_channel #(
  parameter int PAGE_BITS = `CH_PAGE_BITS,
  parameter int BUF_DEPTH = `CH_BUF_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        branch,
  input  wire logic [31:0] branch_vaddr,
  input  wire logic        xl_ack,
  input  wire logic [31:0] xl_paddr,
  input  wire logic        inst_ready,
  input  wire logic        d_req,
  input  wire logic        d_wr,
  input  wire logic        d_copro,
  input  wire logic [31:0] d_addr,
  input  wire logic [31:0] d_wdata,
  input  wire logic        wait_en,
  input  wire logic        irq,
  input  wire logic        interlock,
  input  wire logic        halt_instr,
  input  wire logic [31:0] state_rdata,
  input  wire logic [31:0] ibus_in,
  input  wire logic        ibus_ack,
  input  wire logic        i_pipe_ack,
  input  wire logic        i_burst_ack,
  input  wire logic [31:0] dbus_in,
  input  wire logic        dbus_ack,
  input  wire logic        d_pipe_ack,
  input  wire logic        ext_req,
  input  wire logic        halt_pin,
  input  wire logic        step_pin,
  input  wire logic        lti_pin,
  input  wire logic        test_pin,
  input  wire logic        dev_rd,
  input  wire logic        dev_wr,
  input  wire logic        go_pin,
  output logic [31:0]      addr_out,
  output logic             addr_oe_n,
  output logic [31:0]      dbus_out,
  output logic             dbus_oe_n,
  output logic             ctl_oe_n,
  output logic             i_req,
  output logic             data_req,
  output logic             d_rw,
  output logic             burst_req,
  output logic             copro_sel,
  output logic             ext_grant,
  output logic [2:0]       mode_out,
  output logic             inst_valid,
  output logic [31:0]      inst_data,
  output logic             d_ready,
  output logic             rd_valid,
  output logic [31:0]      rd_data,
  output logic             xl_req,
  output logic [31:0]      xl_vaddr,
  output logic             core_run,
  output logic             state_wr,
  output logic [31:0]      state_wdata
);

  localparam int LW = $clog2(BUF_DEPTH + 1);

  localparam chan_pkg::chan_st_t ST_RST = '{
    mode:      chan_pkg::MODE_RESET,
    ist:       chan_pkg::I_IDLE,
    dst:       chan_pkg::D_IDLE,
    ivp:       `CH_PTR_RST,
    ipp:       `CH_PTR_RST,
    need_xl:   1'b1,
    d_ready:   1'b1,
    addr_oe_n: 1'b1,
    dout_oe_n: 1'b1,
    default:   '0
  };

  chan_pkg::chan_st_t st;
  chan_pkg::chan_st_t next_st;
  logic               push;
  logic [31:0]        push_w;
  logic [LW-1:0]      lvl;

  word_stream_if #(.W(32)) fill_if ();
  word_stream_if #(.W(32)) drain_if ();

  function automatic logic [31:0] step_word(input logic [31:0] a);
    return a + `CH_WORD_STEP;
  endfunction

  function automatic logic burst_region(input logic [31:0] a);
    return a >= `CH_BURST_BASE;
  endfunction

  // fetched words wait here so a stalled consumer loses nothing
  word_buffer #(.W(32), .DEPTH(BUF_DEPTH), .LW(LW)) u_ibuf (
    .clk   (clk),
    .srst  (srst),
    .flush (branch),
    .level (lvl),
    .fill  (fill_if.snk),
    .drain (drain_if.src)
  );

  assign fill_if.valid  = push;
  assign fill_if.data   = push_w;
  assign drain_if.ready = inst_ready;
  assign inst_valid     = drain_if.valid;
  assign inst_data      = drain_if.data;

  // every pin and core-side output except inst_valid and inst_data (from the buffer head) is a field of the state
  assign addr_out    = st.addr;
  assign addr_oe_n   = st.addr_oe_n;
  assign dbus_out    = st.dout;
  assign dbus_oe_n   = st.dout_oe_n;
  assign ctl_oe_n    = st.ctl_oe_n;
  assign i_req       = st.i_req;
  assign data_req    = st.data_req;
  assign d_rw        = st.rw;
  assign burst_req   = st.burst_req;
  assign copro_sel   = st.copro;
  assign ext_grant   = st.grant;
  assign mode_out    = st.mode;
  assign d_ready     = st.d_ready;
  assign rd_valid    = st.rd_valid;
  assign rd_data     = st.rd_data;
  assign xl_req      = st.xl_req;
  assign xl_vaddr    = st.xl_vaddr;
  assign core_run    = st.core_run;
  assign state_wr    = st.state_wr;
  assign state_wdata = st.state_wdata;

  // whole next state; pins are read only after the second sync stage
  always_comb begin
    chan_pkg::pin_t  p;
    chan_pkg::mode_t m;
    logic step_edge;
    logic fetch_ok;
    logic acc_ok;
    logic bus_free;
    logic room;
    logic dstart;
    logic consume;
    logic adv;
    logic dbg;
    logic devrd;
    logic drop;
    next_st = st;
    p       = st.s2;
    m       = chan_pkg::MODE_EXEC;
    dstart  = 1'b0;
    adv     = 1'b0;
    push    = 1'b0;
    push_w  = p.ibus;
    next_st.s1 = {ibus_in, dbus_in, ibus_ack, i_pipe_ack, i_burst_ack, dbus_ack,
                  d_pipe_ack, ext_req, halt_pin, step_pin, lti_pin, test_pin,
                  dev_rd, dev_wr, go_pin};
    next_st.s2       = st.s1;
    next_st.rd_valid = 1'b0;
    next_st.state_wr = 1'b0;
    next_st.copro    = 1'b0;

    // mode selection, highest priority first
    step_edge = p.step && !st.step_prev;
    next_st.step_prev = p.step;
    if (halt_instr) begin
      next_st.halted = 1'b1;                    // set wins over release
    end else if (p.go) begin
      next_st.halted = 1'b0;
    end
    if (p.test) begin
      m = chan_pkg::MODE_TEST;
    end else if (p.lti && (p.halt || st.halted)) begin
      m = chan_pkg::MODE_LTI;
    end else if (p.step) begin
      m = step_edge ? chan_pkg::MODE_EXEC : chan_pkg::MODE_STEP;
    end else if (p.halt || st.halted) begin
      m = chan_pkg::MODE_HALT;
    end else if (wait_en && !irq) begin
      m = chan_pkg::MODE_WAIT;
    end else if (interlock) begin
      m = chan_pkg::MODE_HOLD;
    end
    next_st.mode     = m;
    next_st.core_run = m == chan_pkg::MODE_EXEC;

    fetch_ok = st.mode == chan_pkg::MODE_EXEC || st.mode == chan_pkg::MODE_HOLD;
    acc_ok   = fetch_ok || st.mode == chan_pkg::MODE_LTI;
    room     = fill_if.ready && (int'(lvl) + int'(st.ipend)) < BUF_DEPTH;

    // grant only between address phases, so no held address is cut off
    if (!p.ext_req) begin
      next_st.grant = 1'b0;
    end else if (st.ist != chan_pkg::I_ADDR && st.dst != chan_pkg::D_ADDR) begin
      next_st.grant = 1'b1;
    end
    bus_free = !st.grant && !p.ext_req && st.mode != chan_pkg::MODE_TEST;

    // translated request slot, refilled while the bus is busy
    if (d_req && st.d_ready) begin
      next_st.dq_v  = 1'b1;
      next_st.dq_wr = d_wr;
      next_st.dq_cp = d_copro;
      next_st.dq_a  = d_addr;
      next_st.dq_w  = d_wdata;
    end

    // data channel: it may start even while an instruction burst runs
    unique case (st.dst)
      chan_pkg::D_IDLE: begin
        if (st.dq_v && acc_ok && bus_free && st.ist != chan_pkg::I_ADDR) begin
          dstart       = 1'b1;
          next_st.dq_v = 1'b0;
          next_st.addr = st.dq_a;
          next_st.dout = st.dq_w;
          if (st.dq_cp) begin
            next_st.copro = 1'b1;               // 64 bits in one cycle
          end else begin
            next_st.dst      = chan_pkg::D_ADDR;
            next_st.data_req = 1'b1;
            next_st.rw       = !st.dq_wr;
            next_st.d_wr     = st.dq_wr;
          end
        end
      end
      chan_pkg::D_ADDR, chan_pkg::D_WAIT: begin
        if (p.d_ack) begin
          next_st.dst      = chan_pkg::D_IDLE;  // address held till here
          next_st.data_req = 1'b0;
          next_st.rd_valid = !st.d_wr;
          next_st.rd_data  = p.dbus;
        end else if (st.dst == chan_pkg::D_ADDR && p.d_pipe) begin
          next_st.data_req = 1'b0;              // late switch to pipelined
          next_st.dst      = chan_pkg::D_WAIT;
        end
      end
      default: begin
        next_st.dst = chan_pkg::D_IDLE;
      end
    endcase

    // instruction replies; stale ones after a branch are dropped
    consume = p.i_ack && (st.ist == chan_pkg::I_BURST || st.ipend != 2'h0);
    if (consume) begin
      if (st.ipend != 2'h0) begin
        next_st.ipend = st.ipend - 2'h1;
      end else begin
        adv = 1'b1;                             // next burst word, no address
      end
      if (st.idrop != 2'h0) begin
        next_st.idrop = st.idrop - 2'h1;
      end else begin
        push = !st.bstale;
      end
    end else if (st.mode == chan_pkg::MODE_LTI && p.i_ack) begin
      push = 1'b1;                              // injected, pointer untouched
    end

    // instruction channel
    unique case (st.ist)
      chan_pkg::I_IDLE: begin
        if (st.need_xl) begin
          next_st.ist      = chan_pkg::I_XLATE;
          next_st.xl_req   = 1'b1;
          next_st.xl_vaddr = st.ivp;
        end else if (fetch_ok && bus_free && !dstart && room &&
                     st.dst != chan_pkg::D_ADDR && int'(st.ipend) < `CH_MAX_OUT) begin
          next_st.ist       = chan_pkg::I_ADDR;
          next_st.i_req     = 1'b1;
          next_st.addr      = st.ipp;
          next_st.burst_req = burst_region(st.ipp) && st.ipend == 2'h0 &&
                              lvl == '0;
          next_st.ipend     = next_st.ipend + 2'h1;
          adv               = 1'b1;
        end
      end
      chan_pkg::I_ADDR: begin
        if (p.i_burst && st.burst_req && st.ipend == 2'h1) begin
          next_st.i_req = 1'b0;                 // responder took a burst
          next_st.ist   = chan_pkg::I_BURST;
        end else if (p.i_ack || p.i_pipe) begin
          next_st.i_req     = 1'b0;
          next_st.burst_req = 1'b0;
          next_st.ist       = chan_pkg::I_IDLE;
        end
      end
      chan_pkg::I_BURST: begin
        if (!p.i_burst) begin
          next_st.burst_req = 1'b0;             // responder ended it
          next_st.bstale    = 1'b0;
          next_st.ipend     = 2'h0;
          next_st.ist       = chan_pkg::I_IDLE;
        end else if (st.need_xl || !fetch_ok || lvl != '0 || branch) begin
          next_st.burst_req = 1'b0;             // our end; words still land
        end
      end
      chan_pkg::I_XLATE: begin
        if (xl_ack) begin
          next_st.xl_req  = 1'b0;
          next_st.ipp     = xl_paddr;
          next_st.need_xl = 1'b0;
          next_st.ist     = chan_pkg::I_IDLE;
        end
      end
    endcase

    // pointer steps; a fresh page needs a translation first
    if (adv) begin
      next_st.ivp = step_word(st.ivp);
      next_st.ipp = step_word(st.ipp);
      if (next_st.ivp[PAGE_BITS-1:0] == '0) begin
        next_st.need_xl = 1'b1;
        next_st.burst_req = 1'b0;
      end
    end

    // a branch restarts the stream; replies in flight become stale
    if (branch) begin
      next_st.ivp       = branch_vaddr;
      next_st.need_xl   = 1'b1;
      next_st.idrop     = next_st.ipend;
      next_st.burst_req = 1'b0;
      next_st.bstale    = next_st.ist == chan_pkg::I_BURST;
      if (st.ist == chan_pkg::I_XLATE) begin
        next_st.ist    = chan_pkg::I_IDLE;
        next_st.xl_req = 1'b0;
      end
    end

    // development access to processor state over the data bus
    dbg = st.mode == chan_pkg::MODE_HALT || st.mode == chan_pkg::MODE_STEP ||
          st.mode == chan_pkg::MODE_LTI;
    devrd = dbg && p.dev_rd && st.dst == chan_pkg::D_IDLE && !dstart;
    if (devrd) begin
      next_st.dout = state_rdata;
    end
    if (dbg && p.dev_wr) begin
      next_st.state_wr    = 1'b1;
      next_st.state_wdata = p.dbus;
    end

    // pin enables; test mode or a granted master releases everything
    drop = m == chan_pkg::MODE_TEST || next_st.grant;
    next_st.ctl_oe_n  = drop;
    next_st.addr_oe_n = drop || !(next_st.i_req || next_st.data_req || next_st.copro);
    next_st.dout_oe_n = drop || !((next_st.dst != chan_pkg::D_IDLE && next_st.d_wr) ||
                                  next_st.copro || devrd);
    next_st.d_ready   = !next_st.dq_v;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

endmodule // proc_channel
`default_nettype wire

// ---- dv/proc_channel_assertions.sv ----
// port assertions for the channel controller
`timescale 1ns/1ps
`default_nettype none
module proc_channel_chk (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        d_req,
  input wire logic        d_ready,
  input wire logic        i_req,
  input wire logic [31:0] addr_out,
  input wire logic        addr_oe_n,
  input wire logic        dbus_oe_n,
  input wire logic        ctl_oe_n,
  input wire logic        ext_grant,
  input wire logic [2:0]  mode_out,
  input wire logic        core_run,
  input wire logic        rd_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // mode code and strobes tied to their causes
  reset_code_a: assert property ($fell(srst) |-> mode_out == 3'h7)
    else $error("mode code not reset");
  run_code_a: assert property (core_run |-> mode_out == 3'h0)
    else $error("core runs outside exec code");
  halt_fetch_a: assert property (
    $rose(i_req) |-> !($past(mode_out) inside {3'h1, 3'h3, 3'h6}))
    else $error("fetch began while stopped");
  // one cycle of settling allowed before the pins float
  test_float_a: assert property (
    mode_out == 3'h6 && $past(mode_out) == 3'h6 |-> addr_oe_n && dbus_oe_n && ctl_oe_n)
    else $error("outputs driven in test");
  addr_hold_a: assert property (
    i_req && $past(i_req) && mode_out != 3'h6 |-> $stable(addr_out) && !addr_oe_n)
    else $error("fetch address moved");
  rd_pulse_a: assert property (rd_valid |=> !rd_valid)
    else $error("read result longer than a cycle");
  slot_take_a: assert property (d_req && d_ready |=> !d_ready)
    else $error("slot still free after take");
  grant_float_a: assert property (
    ext_grant && $past(ext_grant) |-> addr_oe_n && dbus_oe_n)
    else $error("bus driven while granted");
endmodule // proc_channel_chk

bind proc_channel proc_channel_chk i_chk (
  .clk, .srst, .d_req, .d_ready, .i_req, .addr_out, .addr_oe_n, .dbus_oe_n, .ctl_oe_n,
  .ext_grant, .mode_out, .core_run, .rd_valid
);
`default_nettype wire

// ---- dv/chan_mem_model.sv ----
// memory responder for the fetch and data channels
`timescale 1ns/1ps
`default_nettype none
module chan_mem_model (
  input  wire logic        clk,
  input  wire logic [1:0]  lat,
  input  wire logic        i_req,
  input  wire logic        data_req,
  input  wire logic [31:0] addr_out,
  output logic [31:0]      ibus_in,
  output logic             ibus_ack,
  output logic [31:0]      dbus_in,
  output logic             dbus_ack
);
  int          ci = -1;
  int          cd = -1;
  logic [31:0] ia;
  logic [31:0] da;
  initial begin
    {ibus_in, ibus_ack, dbus_in, dbus_ack} = '0;
  end
  // one reply per address phase, lat+1 cycles after the phase is first sampled; idle lines toggle so no stale word
  always @(posedge clk) begin
    ibus_ack <= 1'b0;
    dbus_ack <= 1'b0;
    ibus_in  <= ~ibus_in;
    dbus_in  <= ~dbus_in;
    if (!i_req) ci <= -1;
    else if (ci == -1 || addr_out != ia) begin
      ci <= lat;
      ia <= addr_out;
    end else if (ci == 0) begin
      ci       <= -2;
      ibus_ack <= 1'b1;
      ibus_in  <= addr_out ^ 32'h5A5A5A5A;
    end else if (ci > 0) ci <= ci - 1;
    if (!data_req) cd <= -1;
    else if (cd == -1 || addr_out != da) begin
      cd <= lat;
      da <= addr_out;
    end else if (cd == 0) begin
      cd       <= -2;
      dbus_ack <= 1'b1;
      dbus_in  <= addr_out ^ 32'hC3C3C3C3;
    end else if (cd > 0) cd <= cd - 1;
  end
endmodule // chan_mem_model
`default_nettype wire

// ---- dv/proc_channel_tb_top.sv ----
// self-checking bench for the channel controller
`timescale 1ns/1ps
`default_nettype none
module proc_channel_tb_top;
  localparam logic [31:0] OFS = 32'h00010000;
  logic        clk, srst, branch, xl_ack, inst_ready, d_req, d_wr, d_copro, wait_en, irq;
  logic        interlock, halt_instr, ext_req, halt_pin, step_pin, test_pin, dev_wr, go_pin;
  logic        addr_oe_n, dbus_oe_n, ctl_oe_n, i_req, data_req, d_rw, burst_req, copro_sel;
  logic        ext_grant, inst_valid, d_ready, rd_valid, xl_req, core_run, state_wr;
  logic        ibus_ack, dbus_ack, dev_rd, lti_pin;
  logic [1:0]  lat;
  logic [2:0]  mode_out;
  logic [31:0] branch_vaddr, xl_paddr, d_addr, d_wdata, state_rdata, addr_out, dbus_out;
  logic [31:0] inst_data, rd_data, xl_vaddr, state_wdata, ibus_in, dbus_in, ev, cpw;
  logic [31:0] rq[$];
  int          fails, checked, runs, seed, i;

  proc_channel i_dut (
    .clk, .srst, .branch, .branch_vaddr, .xl_ack, .xl_paddr, .inst_ready, .d_req, .d_wr,
    .d_copro, .d_addr, .d_wdata, .wait_en, .irq, .interlock, .halt_instr, .state_rdata,
    .ibus_in, .ibus_ack, .i_pipe_ack(1'b0), .i_burst_ack(1'b0), .dbus_in, .dbus_ack,
    .d_pipe_ack(1'b0), .ext_req, .halt_pin, .step_pin, .lti_pin, .test_pin,
    .dev_rd, .dev_wr, .go_pin, .addr_out, .addr_oe_n, .dbus_out, .dbus_oe_n,
    .ctl_oe_n, .i_req, .data_req, .d_rw, .burst_req, .copro_sel, .ext_grant, .mode_out,
    .inst_valid, .inst_data, .d_ready, .rd_valid, .rd_data, .xl_req, .xl_vaddr, .core_run,
    .state_wr, .state_wdata
  );
  chan_mem_model i_mem (
    .clk, .lat, .i_req, .data_req, .addr_out, .ibus_in, .ibus_ack, .dbus_in, .dbus_ack
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // bounded wait for a mode code; a miss ends the run
  task automatic wmode(input logic [2:0] m);
    for (i = 0; i < 30 && mode_out !== m; i++) @(posedge clk);
    chk(mode_out, m);
    if (mode_out !== m) final_report;
  endtask

  // one data request, held until an edge that samples the slot free
  task automatic dreq(input logic wr, input logic cp, input logic [31:0] a);
    @(posedge clk);
    d_req   <= 1'b1;
    d_wr    <= wr;
    d_copro <= cp;
    d_addr  <= a;
    d_wdata <= $random(seed);
    @(posedge clk);
    for (i = 0; i < 60 && d_ready !== 1'b1; i++) @(posedge clk);
    chk(d_ready, 1'b1);
    if (d_ready !== 1'b1) final_report;
    d_req <= 1'b0;
    if (!wr && !cp) rq.push_back(a ^ 32'hC3C3C3C3);
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // linear translation, stream order and read results against the model
  always @(posedge clk) begin
    xl_ack   <= xl_req && !xl_ack;
    xl_paddr <= xl_vaddr + OFS;
    if (core_run) runs <= runs + 1;
    if (copro_sel) chk(addr_out, cpw);
    if (inst_valid && inst_ready) begin
      chk(inst_data, (ev + OFS) ^ 32'h5A5A5A5A);
      ev <= ev + 32'h4;
    end
    if (rd_valid) begin
      chk({31'h0, rq.size() > 0}, 32'h1);
      if (rq.size() > 0) chk(rd_data, rq.pop_front());
    end
  end

  initial begin
    seed = 32'h5EF41C7E;
    {srst, inst_ready} = 2'h3;
    {branch, xl_ack, d_req, d_wr, d_copro, wait_en, irq, interlock, halt_instr} = '0;
    {ext_req, halt_pin, step_pin, test_pin, dev_wr, dev_rd, lti_pin, go_pin, lat} = '0;
    {branch_vaddr, xl_paddr, d_addr, d_wdata, ev, cpw} = '0;
    state_rdata = 32'hA5A50F0F;
    {fails, checked, runs} = '0;
    tick(2);
    srst <= 1'b0;
    wmode(3'h0);
    // stalling consumer and varied latency; long enough to cross a page
    repeat (3000) begin
      @(posedge clk);
      inst_ready <= $random(seed);
      lat        <= $random(seed);
    end
    dreq(1'b0, 1'b0, 32'h00002000);
    dreq(1'b0, 1'b0, 32'h00002004);
    tick(1);
    if (d_ready === 1'b0) begin
      d_req  <= 1'b1;
      d_addr <= 32'h00003000;
      tick(1);
      d_req <= 1'b0;
    end
    dreq(1'b1, 1'b0, 32'h00002008);
    cpw = 32'h00C0FFEE;
    dreq(1'b1, 1'b1, cpw);
    tick(60);
    chk(rq.size(), 32'h0);
    @(posedge clk);
    inst_ready   <= 1'b0;
    branch       <= 1'b1;
    branch_vaddr <= 32'h00000800;
    @(posedge clk);
    branch     <= 1'b0;
    inst_ready <= 1'b1;
    ev = 32'h00000800;
    tick(400);
    wait_en <= 1'b1;
    wmode(3'h1);
    irq <= 1'b1;
    wmode(3'h0);
    {wait_en, irq} <= 2'h0;
    interlock <= 1'b1;
    wmode(3'h2);
    interlock <= 1'b0;
    wmode(3'h0);
    halt_pin <= 1'b1;
    wmode(3'h3);
    runs = 0;
    step_pin <= 1'b1;
    tick(6);
    chk(mode_out, 3'h4);
    step_pin <= 1'b0;
    tick(6);
    chk(runs, 32'h1);
    dev_wr <= 1'b1;
    dev_rd <= 1'b1;
    tick(5);
    chk(state_wr, 1'b1);
    chk(dbus_out, state_rdata);
    chk(dbus_oe_n, 1'b0);
    {dev_rd, dev_wr, halt_pin} <= 3'h0;
    wmode(3'h0);
    halt_instr <= 1'b1;
    tick(1);
    halt_instr <= 1'b0;
    wmode(3'h3);
    lti_pin <= 1'b1;
    wmode(3'h5);
    lti_pin <= 1'b0;
    wmode(3'h3);
    go_pin <= 1'b1;
    tick(1);
    go_pin <= 1'b0;
    wmode(3'h0);
    test_pin <= 1'b1;
    wmode(3'h6);
    tick(3);
    chk({addr_oe_n, dbus_oe_n, ctl_oe_n}, 3'h7);
    test_pin <= 1'b0;
    wmode(3'h0);
    ext_req <= 1'b1;
    for (i = 0; i < 40 && ext_grant !== 1'b1; i++) @(posedge clk);
    chk(ext_grant, 1'b1);
    if (ext_grant !== 1'b1) final_report;
    ext_req <= 1'b0;
    tick(10);
    // reset in mid-run restarts the stream at address zero
    inst_ready <= 1'b0;
    srst       <= 1'b1;
    tick(2);
    chk(mode_out, 3'h7);
    srst       <= 1'b0;
    inst_ready <= 1'b1;
    ev = '0;
    wmode(3'h0);
    tick(300);
    final_report;
  end
endmodule // proc_channel_tb_top
`default_nettype wire
